// >>> src/arb_pkg.sv
// package of constants and types for the bus arbitration and
// cycle termination block
// assumes a single 25 MHz clock and synchronous active-high reset
package arb_pkg;
   // -------------------------------------------------------------
   // timing
   // -------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 40;
   // bus states per cycle, S0..S7 walked two per clock by counter
   localparam logic [2:0] ST_S0   = 3'h0;
   localparam logic [2:0] ST_S4   = 3'h2;
   localparam logic [2:0] ST_S7   = 3'h3;
   // cycles halt must trail the error release for a clean re-run
   localparam logic [1:0] RERUN_GAP = 2'h1;
   // regrant window after grant negation, in clocks
   localparam logic [1:0] REGRANT_MAX = 2'h2;
   // exception entry length in bus cycles, all four reads at ERR_VECTOR_ADDR
   localparam logic [2:0] EXC_CYCLES = 3'h4;
   localparam logic [23:0] ERR_VECTOR_ADDR = 24'h000008;

   // -------------------------------------------------------------
   // arbitration states
   // -------------------------------------------------------------
   typedef enum logic [4:0] {
      ARB_IDLE    = 5'b00001,
      ARB_WAITAS  = 5'b00010,
      ARB_GRANT   = 5'b00100,
      ARB_OWNED   = 5'b01000,
      ARB_REGRANT = 5'b10000
   } arb_state_t;

   // -------------------------------------------------------------
   // bus cycle states
   // -------------------------------------------------------------
   typedef enum logic [6:0] {
      CYC_IDLE  = 7'b0000001,
      CYC_RUN   = 7'b0000010,
      CYC_ERRHD = 7'b0000100,
      CYC_RHALT = 7'b0001000,
      CYC_EXC   = 7'b0010000,
      CYC_HALT  = 7'b0100000,
      CYC_DEAD  = 7'b1000000
   } cyc_state_t;
endpackage

// >>> src/arb_unit.sv
// bus arbitration state machine (grant and three-state control)
// assumes request inputs are already synchronised to clk
`timescale 1ns/10ps
`default_nettype none
module arb_unit
   import arb_pkg::*;
(
   // clock and reset
   input  wire logic clk,
   input  wire logic sys_rst,
   // synchronised requests, active high
   input  wire logic reqInt,
   input  wire logic ackInt,
   // cycle status from the termination machine
   input  wire logic cycStartNoAs,
   input  wire logic strobeOn,
   // outputs, active high
   output logic      grantOut,
   output logic      threeState
);
   typedef struct packed {
      arb_state_t st;
      logic [1:0] cnt;
   } arb_reg_t;

   arb_reg_t r, nxt;

   always_comb begin
      nxt = r;
      case (r.st)
         ARB_IDLE: begin
            if (reqInt && cycStartNoAs)
               nxt.st = ARB_WAITAS; // R7
            else if (reqInt)
               nxt.st = ARB_GRANT; // R5
         end
         ARB_WAITAS: begin
            // grant one edge later, once the strobe is out
            if (!reqInt)
               nxt.st = ARB_IDLE;
            else
               nxt.st = ARB_GRANT; // R7
         end
         ARB_GRANT: begin
            if (ackInt)
               nxt.st = ARB_OWNED;
            else if (!reqInt)
               nxt.st = ARB_IDLE;
         end
         ARB_OWNED: begin
            nxt.cnt = 2'h0;
            if (!ackInt)
               nxt.st = ARB_IDLE;
            else if (reqInt)
               nxt.st = ARB_REGRANT; // R2
         end
         ARB_REGRANT: begin
            // grant reasserted within a bounded count of clocks
            nxt.cnt = r.cnt + 2'h1;
            if (r.cnt >= REGRANT_MAX - 2'h1)
               nxt.st = ARB_GRANT; // R2
         end
         default: nxt.st = ARB_IDLE;
      endcase
      if (sys_rst) begin
         nxt.st  = ARB_IDLE; // R25
         nxt.cnt = 2'h0;
      end
   end

   always_ff @(posedge clk) begin
      r <= nxt;
   end

   assign grantOut   = (r.st == ARB_GRANT);
   // the bus stays released while the other master holds it and
   // during the regrant gap, so no cycle can start there
   assign threeState = (r.st == ARB_OWNED) || (r.st == ARB_REGRANT)
                       || ((r.st == ARB_GRANT) && !strobeOn); // R3 R6
endmodule
`default_nettype wire

// >>> src/bus_term_ctrl.sv
// bus arbitration and bus cycle termination control
// Operation
// R1: granted master drops its request after asserting its acknowledge.
// R2: pending request after grant negation gets grant again within clocks.
// R3: no external bus cycle starts between grant negation and regrant.
// R4: every async input passes a short synchroniser before use.
// R5: grant and three-state update on first edge after valid input.
// R6: three-state control floats buses once the strobe is negated.
// R7: request during S0 before strobe delays grant by one edge.
// R8: bus error ends cycle; early error negates strobe in S7.
// R9: buses float while error held; stacking waits for its release.
// R10: error entry stacks state then fetches vector two. The code stacks nothing and runs four reads at ERR_VECTOR_ADDR instead.
// R11: error with halt ends cycle, floats, waits, then repeats it.
// R12: outside logic releases error a clock before halt.
// R13: locked read-modify-write cycle never re-runs; error taken instead.
// R14: halt held idles; release and reassert runs one bus cycle.
// R15: cycle completed under halt floats address and data lines.
// R16: arbitration continues normally while halted.
// R17: second bus error before next instruction is double fault, halt.
// R18: re-runs do not count toward double fault; repeat unbounded.
// R19: error before first instruction halts until external reset.
// R20: outside logic changes terminations on rising clock edges.
// R21: error in lieu of or before acknowledge is error termination.
// R22: halt with error re-runs; halt released a cycle after error.
// R23: outside logic releases acknowledge and error with the strobe.
// R24: requester waits for strobe, acknowledge, grant ack negated.
// R25: reset returns arbitration to idle, grant off, float off.
// assumes a core that raises cycReq for each bus cycle it needs and
// a single clock; pins are active low and sampled asynchronously
`timescale 1ns/10ps
`default_nettype none
module bus_term_ctrl
   import arb_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // arbitration pins
   input  wire logic        bus_request_n,
   input  wire logic        grant_acknowledge_n,
   output logic             bus_grant_n,
   // termination pins
   input  wire logic        transfer_acknowledge_n,
   input  wire logic        bus_error_n,
   input  wire logic        haltIn_n,
   // core side cycle request
   input  wire logic        cycReq,
   input  wire logic        cycRmw,
   input  wire logic        cycWrite,
   input  wire logic [23:0] cycAddr,
   input  wire logic [15:0] cycWdata,
   input  wire logic        instrStart,
   output logic             cycDone,
   output logic             excActive,
   // bus drive
   output logic             address_strobe_n,
   output logic [23:0]      busAddr,
   output logic             busWrite,
   output logic [15:0]      busWdata,
   output logic             busAddrOe,
   output logic             busDataOe,
   output logic             busCtrlOe,
   output logic             haltedOut
);
   // -------------------------------------------------------------
   // state
   // -------------------------------------------------------------
   typedef struct packed {
      logic [1:0]  reqSy;
      logic [1:0]  ackSy;
      logic [1:0]  dtSy;
      logic [1:0]  beSy;
      logic [1:0]  hlSy;
      cyc_state_t  st;
      logic [2:0]  ph;
      logic        early;
      logic        strobe;
      logic        lockRmw;
      logic [23:0] addr;
      logic [15:0] wdata;
      logic        wr;
      logic        float;
      logic        done;
      logic        excPend;
      logic        inExc;
      logic        booted;
      logic [2:0]  excCnt;
      logic        gapOk;
   } ctl_reg_t;

   ctl_reg_t r, nxt;

   logic reqInt, ackInt, dtInt, beInt, hlInt;
   logic grantOut, threeState;
   logic cycStartNoAs;

   // -------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------
   // an exception raised while one is already being entered, or
   // before any instruction, is fatal
   function automatic logic fatalErr(input logic inExc,
                                     input logic booted);
      fatalErr = inExc || !booted;
   endfunction

   // -------------------------------------------------------------
   // synchronised pins, second stage only is read
   // -------------------------------------------------------------
   assign reqInt = r.reqSy[1]; // R4
   assign ackInt = r.ackSy[1]; // R4
   assign dtInt  = r.dtSy[1];
   assign beInt  = r.beSy[1];
   assign hlInt  = r.hlSy[1];

   assign cycStartNoAs = (r.st == CYC_RUN) && (r.ph == ST_S0);

   arb_unit u_arb (
      .clk          (clk),
      .sys_rst      (sys_rst),
      .reqInt       (reqInt),
      .ackInt       (ackInt),
      .cycStartNoAs (cycStartNoAs),
      .strobeOn     (r.strobe),
      .grantOut     (grantOut),
      .threeState   (threeState)
   );

   // -------------------------------------------------------------
   // cycle termination machine
   // -------------------------------------------------------------
   always_comb begin
      nxt = r;
      nxt.reqSy = {r.reqSy[0], ~bus_request_n};
      nxt.ackSy = {r.ackSy[0], ~grant_acknowledge_n};
      nxt.dtSy  = {r.dtSy[0], ~transfer_acknowledge_n};
      nxt.beSy  = {r.beSy[0], ~bus_error_n};
      nxt.hlSy  = {r.hlSy[0], ~haltIn_n};
      nxt.done  = 1'b0;
      if (instrStart) begin
         nxt.booted = 1'b1;
         nxt.inExc  = 1'b0;
      end
      case (r.st)
         CYC_IDLE: begin
            // halt held keeps the core idle; arbitration still runs
            nxt.float = hlInt || threeState; // R15 R16
            // a pending request is served first, so a fresh strobe
            // never meets a grant that the other master may take
            if (!hlInt && !threeState && !reqInt
                && (cycReq || r.excPend)) begin
               nxt.st      = CYC_RUN; // R3 R14
               nxt.ph      = ST_S0;
               nxt.float   = 1'b0;
               nxt.early   = 1'b0;
               if (r.excPend) begin
                  nxt.addr    = ERR_VECTOR_ADDR; // R10
                  nxt.wr      = 1'b0;
                  nxt.lockRmw = 1'b0;
               end else begin
                  nxt.addr    = cycAddr;
                  nxt.wr      = cycWrite;
                  nxt.wdata   = cycWdata;
                  nxt.lockRmw = cycRmw;
               end
            end
         end
         CYC_RUN: begin
            if (r.ph != ST_S7)
               nxt.ph = r.ph + 3'h1;
            if (r.ph == ST_S0)
               nxt.strobe = 1'b1;
            if (beInt && r.ph < ST_S4)
               nxt.early = 1'b1;
            if (beInt && r.ph >= ST_S4) begin
               // terminate; strobe dropped in S7 either direction
               nxt.strobe = 1'b0; // R8 R21
               nxt.float  = 1'b1;
               if (hlInt && !r.lockRmw) begin
                  nxt.st = CYC_RHALT; // R11 R22
               end else begin
                  nxt.st = CYC_ERRHD; // R9 R13
               end
            end else if (dtInt && r.ph >= ST_S4 && !r.early) begin
               nxt.strobe = 1'b0;
               nxt.st     = CYC_IDLE;
               nxt.done   = !r.excPend;
               nxt.float  = hlInt; // R15
               if (r.excPend) begin
                  nxt.excCnt = r.excCnt - 3'h1;
                  if (r.excCnt == 3'h1)
                     nxt.excPend = 1'b0;
               end
            end else if (r.early && r.ph == ST_S7) begin
               nxt.strobe = 1'b0; // R8
            end
         end
         CYC_ERRHD: begin
            // hold the buses off until the error line goes away
            nxt.float = 1'b1; // R9
            if (!beInt) begin
               if (fatalErr(r.inExc, r.booted)) begin
                  nxt.st = CYC_DEAD; // R17 R19
               end else begin
                  nxt.st      = CYC_IDLE;
                  nxt.excPend = 1'b1; // R10
                  nxt.inExc   = 1'b1;
                  nxt.excCnt  = EXC_CYCLES;
               end
            end
         end
         CYC_RHALT: begin
            // re-run: no exception counted, cycle kept intact
            nxt.float = 1'b1;
            if (!beInt)
               nxt.gapOk = 1'b1;
            if (!hlInt && !r.gapOk) begin
               // halt let go with or ahead of the error: trap instead
               nxt.st    = CYC_ERRHD; // R22
               nxt.gapOk = 1'b0;
            end else if (!hlInt && !beInt && !threeState && !reqInt) begin
               nxt.st    = CYC_RUN; // R11 R18
               nxt.ph    = ST_S0;
               nxt.early = 1'b0;
               nxt.float = 1'b0;
               nxt.gapOk = 1'b0;
            end
         end
         CYC_DEAD: begin
            // only reset leaves here
            nxt.float  = 1'b1; // R19
            nxt.strobe = 1'b0;
         end
         default: nxt.st = CYC_IDLE;
      endcase
      if (sys_rst) begin
         nxt         = '0;
         nxt.st      = CYC_IDLE;
      end
   end

   always_ff @(posedge clk) begin
      r <= nxt;
   end

   // -------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------
   assign bus_grant_n      = ~grantOut; // R5
   assign address_strobe_n = ~r.strobe;
   assign busAddr          = r.addr;
   assign busWdata         = r.wdata;
   assign busWrite         = r.wr;
   // float only once the strobe has dropped
   assign busAddrOe = !r.strobe ? !(r.float || threeState) : 1'b1; // R6
   assign busDataOe = busAddrOe && r.wr && (r.st == CYC_RUN);
   assign busCtrlOe = !r.strobe ? !threeState : 1'b1; // R6
   assign cycDone   = r.done;
   assign excActive = r.excPend;
   assign haltedOut = (r.st == CYC_DEAD) || (r.st == CYC_RHALT)
                      || (r.st == CYC_IDLE && hlInt && r.float);
endmodule
`default_nettype wire

// >>> verif/bus_term_ctrl_asserts.sv
// checker for arbitration and termination behaviour at the pins
// assumes bind onto bus_term_ctrl; one clock domain
`timescale 1ns/10ps
`default_nettype none
module bus_term_ctrl_asserts (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic bus_request_n,
   input wire logic grant_acknowledge_n,
   input wire logic bus_grant_n,
   input wire logic bus_error_n,
   input wire logic haltIn_n,
   input wire logic cycRmw,
   input wire logic address_strobe_n,
   input wire logic busAddrOe,
   input wire logic busDataOe,
   input wire logic busCtrlOe,
   input wire logic haltedOut
);
   // ----------------------------------------------------------
   // properties
   // ----------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic [3:0] haltCnt_r;
   // saturating count of clocks with halt held low
   always_ff @(posedge clk) begin
      if (sys_rst || haltIn_n) haltCnt_r <= 4'h0;
      else if (haltCnt_r != 4'hf) haltCnt_r <= haltCnt_r + 4'h1;
   end
   AST_RST_IDLE: assert property (disable iff (1'b0)
      sys_rst |=> bus_grant_n && address_strobe_n) else $error("reset");
   AST_SYNC_HOLD: assert property ($fell(bus_request_n) && bus_grant_n
      |=> bus_grant_n [*2]) else $error("grant early");
   AST_GRANT_SOON: assert property ($fell(bus_request_n)
      |-> ##[3:4] !bus_grant_n) else $error("grant late");
   AST_REGRANT: assert property ($rose(bus_grant_n) && !bus_request_n
      |-> ##[1:6] !bus_grant_n) else $error("no regrant");
   AST_NO_START: assert property ($rose(bus_grant_n) && !bus_request_n
      |-> address_strobe_n [*3]) else $error("cycle in gap");
   AST_FLOAT: assert property (!grant_acknowledge_n && address_strobe_n
      && !$past(grant_acknowledge_n, 3)
      |-> !busAddrOe && !busDataOe && !busCtrlOe) else $error("not floated");
   AST_HALT_IDLE: assert property (haltCnt_r > 4'h4 && address_strobe_n
      |=> address_strobe_n) else $error("cycle while halted");
   AST_HALT_FLOAT: assert property (haltedOut && address_strobe_n
      |-> !busAddrOe && !busDataOe) else $error("halt drives bus");
   AST_BUS_ERROR_N_END: assert property (!address_strobe_n && !bus_error_n
      && !cycRmw |-> ##[1:4] address_strobe_n) else $error("no error end");
   AST_BUS_ERROR_N_FLOAT: assert property (!bus_error_n && address_strobe_n
      |-> !busAddrOe && !busDataOe)
      else $error("error drives bus");
   AST_RERUN_WAIT: assert property (!address_strobe_n && !bus_error_n
      && !haltIn_n && !cycRmw |-> ##[1:6] haltedOut) else $error("no wait");
endmodule
bind bus_term_ctrl bus_term_ctrl_asserts chk (.clk, .sys_rst, .bus_request_n,
   .grant_acknowledge_n, .bus_grant_n, .bus_error_n, .haltIn_n, .cycRmw,
   .address_strobe_n, .busAddrOe, .busDataOe, .busCtrlOe, .haltedOut);
`default_nettype wire

// >>> verif/term_partner.sv
// slave, watchdog and alternate master model on the far side
// assumes its registered lines change on rising edges; haltIn_n and bus_request_n also follow haltHold and pend
`timescale 1ns/10ps
`default_nettype none
module term_partner (
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic [1:0] mode,
   input  wire logic [1:0] dly,
   input  wire logic       reqGo,
   input  wire logic       pend,
   input  wire logic       haltHold,
   input  wire logic       address_strobe_n,
   input  wire logic       bus_grant_n,
   output logic            transfer_acknowledge_n,
   output logic            bus_error_n,
   output logic            haltIn_n,
   output logic            bus_request_n,
   output logic            grant_acknowledge_n
);
   // ----------------------------------------------------------
   // behaviour
   // ----------------------------------------------------------
   logic [1:0] cnt, hc;
   logic [2:0] own;
   logic       rh, r;
   // pend stands for a second master on the wired request line
   assign haltIn_n = !(rh || haltHold);
   assign bus_request_n = !(r || pend);
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         {cnt, hc, own, rh, r} <= '0;
         {transfer_acknowledge_n, bus_error_n, grant_acknowledge_n} <= 3'h7;
      end else begin
         if (!address_strobe_n) begin
            cnt <= cnt + 2'h1;
            if (cnt == dly) begin
               transfer_acknowledge_n <= mode != 2'h0;
               bus_error_n <= mode == 2'h0;
               if (mode == 2'h2) rh <= 1'b1;
               hc <= 2'h0;
            end
         end else begin
            cnt <= 2'h0;
            transfer_acknowledge_n <= 1'b1;
            bus_error_n <= 1'b1;
            if (rh && bus_error_n) hc <= hc + 2'h1;
            if (rh && hc == 2'h2) rh <= 1'b0;
         end
         if (reqGo) r <= 1'b1;
         if (r && !bus_grant_n && address_strobe_n && transfer_acknowledge_n
             && grant_acknowledge_n) begin
            r <= 1'b0;
            grant_acknowledge_n <= 1'b0;
            own <= 3'h1;
         end
         if (own != 3'h0) own <= own + 3'h1;
         if (own == 3'h7) grant_acknowledge_n <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// >>> verif/bus_arbitration_and_cycle_termination_tb.sv
// self-checking bench for bus_term_ctrl with far side model
// assumes 25 MHz clock; stimulus changes on falling edges
`timescale 1ns/10ps
`default_nettype none
module bus_arbitration_and_cycle_termination_tb;
   import arb_pkg::*;
   logic        clk, sys_rst, cycReq, cycRmw, cycWrite, instrStart;
   logic        reqGo, pend, haltHold, asPrev;
   logic [23:0] cycAddr, lastAs, busAddr;
   logic [15:0] cycWdata, busWdata;
   logic [1:0]  mode, dly;
   logic [31:0] seed;
   logic        bus_request_n, grant_acknowledge_n, bus_grant_n, haltIn_n;
   logic        transfer_acknowledge_n, bus_error_n, cycDone, excActive;
   logic        address_strobe_n, busWrite, busAddrOe, busDataOe;
   logic        busCtrlOe, haltedOut;
   logic [40:0] expQ[$];
   logic [40:0] ex;
   int          num_errors, n_tests, nAs, n0, i;
   bus_term_ctrl uut (.clk, .sys_rst, .bus_request_n, .grant_acknowledge_n,
      .bus_grant_n, .transfer_acknowledge_n, .bus_error_n, .haltIn_n,
      .cycReq, .cycRmw, .cycWrite, .cycAddr, .cycWdata, .instrStart,
      .cycDone, .excActive, .address_strobe_n, .busAddr, .busWrite,
      .busWdata, .busAddrOe, .busDataOe, .busCtrlOe, .haltedOut);
   term_partner far (.clk, .sys_rst, .mode, .dly, .reqGo, .pend, .haltHold,
      .address_strobe_n, .bus_grant_n, .transfer_acknowledge_n,
      .bus_error_n, .haltIn_n, .bus_request_n, .grant_acknowledge_n);
   // ----------------------------------------------------------
   // helpers
   // ----------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task automatic report_and_stop;
      $display("errors %0d checks %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk1(input string nm, input logic e, input logic s);
      n_tests++;
      if (s !== e) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic chk24(input string nm, input logic [23:0] e, s);
      n_tests++;
      if (s !== e) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask
   function automatic logic hit(input int w);
      case (w)
         0: return cycDone === 1'b1;
         1: return cycDone === 1'b1 || excActive === 1'b1 || haltedOut === 1'b1;
         2: return haltedOut === 1'b1;
         3: return grant_acknowledge_n === 1'b0;
         default: return excActive === 1'b0;
      endcase
   endfunction
   // bounded wait; running out counts as a mismatch
   task automatic wait_for(input int w);
      int k;
      k = 0;
      while (!hit(w)) begin
         @(negedge clk);
         k++;
         if (k > 200) begin
            num_errors++;
            report_and_stop();
         end
      end
   endtask
   task automatic start(input logic [23:0] a, input logic w);
      @(negedge clk);
      seed = lfsr(seed);
      cycAddr = a;
      cycWdata = seed[15:0];
      cycWrite = w;
      cycReq = 1'b1;
      expQ.push_back({w, seed[15:0], a});
   endtask
   task automatic cyc(input logic [23:0] a, input logic w);
      start(a, w);
      wait_for(1);
      cycReq = 1'b0;
   endtask
   task automatic do_reset;
      @(negedge clk);
      sys_rst = 1'b1;
      repeat (6) @(negedge clk);
      sys_rst = 1'b0;
      expQ.delete();
      repeat (2) @(negedge clk);
   endtask
   task automatic boot;
      @(negedge clk);
      instrStart = 1'b1;
      @(negedge clk);
      instrStart = 1'b0;
   endtask
   always @(negedge clk) begin
      if (asPrev === 1'b1 && address_strobe_n === 1'b0) begin
         nAs++;
         lastAs = busAddr;
         // every strobe of a core cycle, re-runs included, carries
         // the same address, direction and write data
         if (expQ.size() > 0 && excActive === 1'b0) begin
            ex = expQ[0];
            chk24("strobe address", ex[23:0], busAddr);
            chk1("strobe write", ex[40], busWrite);
            if (ex[40]) begin
               chk24("write data", {8'h00, ex[39:24]}, {8'h00, busWdata});
            end
         end
      end
      asPrev = address_strobe_n;
      if (cycDone === 1'b1 && expQ.size() > 0) begin
         ex = expQ.pop_front();
         chk24("address", ex[23:0], lastAs);
      end
   end
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // ----------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------
   initial begin
      {sys_rst, cycReq, cycRmw, cycWrite, instrStart} = 5'h10;
      {reqGo, pend, haltHold, asPrev, mode, dly} = 8'h10;
      {cycAddr, cycWdata, lastAs, num_errors, n_tests, nAs} = '0;
      seed = 32'h32907ecf;
      do_reset();
      chk1("grant idle", 1'b1, bus_grant_n);
      chk1("strobe idle", 1'b1, address_strobe_n);
      boot();
      for (i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         dly = seed[26:25];
         cyc({seed[23:1], 1'b0}, seed[24]);
      end
      mode = 2'h2;
      cycRmw = 1'b1;
      cyc(24'h000040, 1'b0);
      chk1("locked trap", 1'b1, excActive);
      {mode, cycRmw} = 3'h0;
      wait_for(4);
      expQ.delete();
      boot();
      n0 = nAs;
      mode = 2'h2;
      start(24'h0000a4, 1'b1);
      wait_for(2);
      mode = 2'h0;
      wait_for(0);
      cycReq = 1'b0;
      chk1("rerun count", 1'b1, nAs - n0 == 2);
      chk1("no trap", 1'b0, excActive);
      haltHold = 1'b1;
      repeat (4) @(negedge clk);
      n0 = nAs;
      start(24'h000100, 1'b0);
      {pend, reqGo} = 2'h3;
      @(negedge clk);
      reqGo = 1'b0;
      wait_for(3);
      repeat (4) @(negedge clk);
      chk1("float", 1'b0, busAddrOe);
      chk1("ctrl float", 1'b0, busCtrlOe);
      pend = 1'b0;
      repeat (12) @(negedge clk);
      chk1("halt idle", 1'b1, nAs == n0);
      chk1("halted", 1'b1, haltedOut);
      haltHold = 1'b0;
      wait_for(0);
      cycReq = 1'b0;
      do_reset();
      mode = 2'h1;
      cyc(24'h000200, 1'b0);
      repeat (20) @(negedge clk);
      chk1("boot fault", 1'b1, haltedOut);
      do_reset();
      boot();
      cyc(24'h000300, 1'b1);
      chk1("trap", 1'b1, excActive);
      wait_for(2);
      chk24("vector", ERR_VECTOR_ADDR, lastAs);
      report_and_stop();
   end
endmodule
`default_nettype wire
